// ### core/prio_bank_pkg.sv
// Constants for the five-register interrupt priority bank
package prio_bank_pkg;
	localparam int REG_COUNT = 5;
	localparam int FIELDS_PER_REG = 4;
	localparam int FIELD_WIDTH = 3;
	localparam int REG_WIDTH = 16;
	localparam int SOURCE_COUNT = 20;
	localparam int ADDR_WIDTH = 4;
	// Register offsets, word index on the register port
	localparam logic [3:0] OFFS_BANK_FIVE = 4'h0;
	localparam logic [3:0] OFFS_BANK_SIX = 4'h1;
	localparam logic [3:0] OFFS_BANK_SEVEN = 4'h2;
	localparam logic [3:0] OFFS_BANK_EIGHT = 4'h3;
	localparam logic [3:0] OFFS_BANK_NINE = 4'h4;
	// Field positions, low bit of each field
	localparam int FIELD_POS_3 = 12;
	localparam int FIELD_POS_2 = 8;
	localparam int FIELD_POS_1 = 4;
	localparam int FIELD_POS_0 = 0;
	// Implemented bits and reset value of each register
	localparam logic [15:0] IMPL_MASK = 16'h7777;
	localparam logic [2:0] FIELD_RESET = 3'h4;
	localparam logic [15:0] REG_RESET = 16'h4444;
	localparam logic [2:0] LEVEL_OFF = 3'h0;
	localparam logic [2:0] LEVEL_MAX = 3'h7;
	localparam logic [15:0] READ_ZERO = 16'h0000;
endpackage : prio_bank_pkg

// ### core/prio_reg_word.sv
// One 16-bit priority register holding four 3-bit fields
`timescale 1ns/1ps
module prio_reg_word
	import prio_bank_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Write side
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	// Stored value
	output logic [15:0] value
);
	logic [15:0] word_q;
	logic [15:0] word_d;

	assign word_d = wr_en ? (wr_data & IMPL_MASK) : word_q;
	assign value = word_q;

	// reset to four, hold written value
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			word_q <= REG_RESET;
		end else begin
			word_q <= word_d;
		end
	end
endmodule : prio_reg_word

// ### core/prio_field_gate.sv
// Per-source level decode and request gating
`timescale 1ns/1ps
module prio_field_gate
	import prio_bank_pkg::*;
(
	// Level and raw request
	input wire logic [2:0] level,
	input wire logic request,
	// Gated request and ranked level
	output logic forward,
	output logic [2:0] ranked
);
	assign forward = request && (level != LEVEL_OFF);
	assign ranked = forward ? level : LEVEL_OFF;
endmodule : prio_field_gate

// ### core/prio_bank.sv
// Interrupt priority register bank five to nine with request gating
`timescale 1ns/1ps
module prio_bank
	import prio_bank_pkg::*;
#(
	parameter int NUM_REGS = REG_COUNT
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Register port
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	// Source requests, index = register*4 + field (field 0 = bits 2:0)
	input wire logic [19:0] src_request,
	// Gated requests and levels toward the arbiter
	output logic [19:0] src_forward,
	output logic [59:0] src_level,
	// Named levels
	output logic [2:0] capture_eight_level,
	output logic [2:0] capture_seven_level,
	output logic [2:0] second_adc_level,
	output logic [2:0] external_one_level,
	output logic [2:0] timer_four_level,
	output logic [2:0] compare_four_level,
	output logic [2:0] compare_three_level,
	output logic [2:0] dma_chan_two_level,
	output logic [2:0] uart_two_tx_level,
	output logic [2:0] uart_two_rx_level,
	output logic [2:0] external_two_level,
	output logic [2:0] timer_five_level,
	output logic [2:0] can_one_event_level,
	output logic [2:0] can_one_rx_level,
	output logic [2:0] spi_two_event_level,
	output logic [2:0] spi_two_error_level,
	output logic [2:0] capture_five_level,
	output logic [2:0] capture_four_level,
	output logic [2:0] capture_three_level,
	output logic [2:0] dma_chan_three_level
);
	logic [15:0] bank [0:REG_COUNT-1];
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic [REG_COUNT-1:0] hit;
	logic mapped;
	logic [3:0] reg_off [0:REG_COUNT-1];

	assign reg_off[0] = OFFS_BANK_FIVE;
	assign reg_off[1] = OFFS_BANK_SIX;
	assign reg_off[2] = OFFS_BANK_SEVEN;
	assign reg_off[3] = OFFS_BANK_EIGHT;
	assign reg_off[4] = OFFS_BANK_NINE;

	// Register storage, field decode and gating per register
	genvar r;
	genvar f;
	generate
		for (r = 0; r < REG_COUNT; r++) begin : g_reg
			assign hit[r] = (addr == reg_off[r]);
			prio_reg_word u_word (
				.clock(clock),
				.reset_n(reset_n),
				.wr_en(wr && hit[r]),
				.wr_data(wdata),
				.value(bank[r])
			);
			for (f = 0; f < FIELDS_PER_REG; f++) begin : g_field
				// field at bits 4f+2 to 4f
				prio_field_gate u_gate (
					.level(bank[r][4*f +: FIELD_WIDTH]),
					.request(src_request[r*FIELDS_PER_REG + f]),
					.forward(src_forward[r*FIELDS_PER_REG + f]),
					.ranked(src_level[(r*FIELDS_PER_REG + f)*FIELD_WIDTH +: FIELD_WIDTH])
				);
			end
		end
	endgenerate

	// Read mux, unmapped offsets read zero
	assign mapped = |hit;
	always_comb begin
		rdata_d = READ_ZERO;
		for (int i = 0; i < REG_COUNT; i++) begin
			if (hit[i]) begin
				rdata_d = bank[i];
			end
		end
	end

	// read data one cycle after strobe
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			rdata_q <= READ_ZERO;
		end else if (rd) begin
			rdata_q <= mapped ? (rdata_d & IMPL_MASK) : READ_ZERO;
		end else begin
			rdata_q <= READ_ZERO;
		end
	end
	assign rdata = rdata_q;

	assign capture_eight_level = bank[0][FIELD_POS_3 +: FIELD_WIDTH];
	assign capture_seven_level = bank[0][FIELD_POS_2 +: FIELD_WIDTH];
	assign second_adc_level = bank[0][FIELD_POS_1 +: FIELD_WIDTH];
	assign external_one_level = bank[0][FIELD_POS_0 +: FIELD_WIDTH];
	assign timer_four_level = bank[1][FIELD_POS_3 +: FIELD_WIDTH];
	assign compare_four_level = bank[1][FIELD_POS_2 +: FIELD_WIDTH];
	assign compare_three_level = bank[1][FIELD_POS_1 +: FIELD_WIDTH];
	assign dma_chan_two_level = bank[1][FIELD_POS_0 +: FIELD_WIDTH];
	assign uart_two_tx_level = bank[2][FIELD_POS_3 +: FIELD_WIDTH];
	assign uart_two_rx_level = bank[2][FIELD_POS_2 +: FIELD_WIDTH];
	assign external_two_level = bank[2][FIELD_POS_1 +: FIELD_WIDTH];
	assign timer_five_level = bank[2][FIELD_POS_0 +: FIELD_WIDTH];
	assign can_one_event_level = bank[3][FIELD_POS_3 +: FIELD_WIDTH];
	assign can_one_rx_level = bank[3][FIELD_POS_2 +: FIELD_WIDTH];
	assign spi_two_event_level = bank[3][FIELD_POS_1 +: FIELD_WIDTH];
	assign spi_two_error_level = bank[3][FIELD_POS_0 +: FIELD_WIDTH];
	assign capture_five_level = bank[4][FIELD_POS_3 +: FIELD_WIDTH];
	assign capture_four_level = bank[4][FIELD_POS_2 +: FIELD_WIDTH];
	assign capture_three_level = bank[4][FIELD_POS_1 +: FIELD_WIDTH];
	assign dma_chan_three_level = bank[4][FIELD_POS_0 +: FIELD_WIDTH];
endmodule : prio_bank

// ### verification/src_model.sv
// Peripheral request sources feeding the priority bank
`timescale 1ns/1ps
module src_model (
	// Clock and wanted pattern
	input wire logic clock,
	input wire logic [19:0] want,
	// Raw requests
	output logic [19:0] src_request
);
	// Requests follow the pattern one edge later
	always_ff @(posedge clock) begin
		src_request <= want;
	end
endmodule : src_model

// ### verification/prio_bank_checker.sv
// Port assertions for the priority bank
`timescale 1ns/1ps
module prio_bank_checker (
	// Watched ports
	input wire logic clock, reset_n, wr, rd,
	input wire logic [3:0] addr,
	input wire logic [15:0] wdata, rdata,
	input wire logic [19:0] src_forward,
	input wire logic [59:0] src_level,
	input wire logic [2:0] capture_eight_level, external_one_level, timer_four_level, timer_five_level,
	input wire logic [2:0] dma_chan_three_level
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	rd_quiet_a: assert property (!$past(rd) |-> rdata == 16'h0) else $error("rdata not idle");
	gap_bits_a: assert property ((rdata & 16'h8888) == 16'h0) else $error("gap bit set");
	reset_val_a: assert property ($rose(reset_n) |-> timer_five_level == 3'h4) else $error("bad reset level");
	off_gate_a: assert property (timer_four_level == 3'h0 |-> !src_forward[7]) else $error("off source passed");
	level_pass_a: assert property (src_forward[7] |-> src_level[23:21] == timer_four_level) else $error("bad rank");
	six_take_a: assert property (wr && addr == 4'h1 |=> timer_four_level == $past(wdata[14:12])) else $error("six lost");
	five_take_a: assert property (wr && addr == 4'h0 |=> capture_eight_level == $past(wdata[14:12])
		&& external_one_level == $past(wdata[2:0])) else $error("five lost");
	nine_hold_a: assert property (!wr |=> $stable(dma_chan_three_level)) else $error("level drift");
endmodule : prio_bank_checker
bind prio_bank prio_bank_checker ck (.*);

// ### verification/tb.sv
// Self-checking bench for the priority bank
`timescale 1ns/1ps
module tb;
	logic clock = 0, reset_n = 0, wr = 0, rd = 0;
	logic [3:0] addr = 4'h0;
	logic [15:0] wdata = 16'h0, rdata;
	logic [15:0] m[8];
	logic [19:0] want = 20'hfffff, src_request, src_forward, e;
	logic [59:0] src_level, x, sl;
	logic [2:0] capture_eight_level, capture_seven_level, second_adc_level, external_one_level, timer_four_level;
	logic [2:0] compare_four_level, compare_three_level, dma_chan_two_level, uart_two_tx_level, uart_two_rx_level;
	logic [2:0] external_two_level, timer_five_level, can_one_event_level, can_one_rx_level, spi_two_event_level;
	logic [2:0] spi_two_error_level, capture_five_level, capture_four_level, capture_three_level, dma_chan_three_level;
	logic [31:0] seed = 32'h4bcf;
	int errors = 0, n_tests = 0;
	prio_bank dut (.*);
	src_model far (.*);
	initial forever #20 clock = ~clock;
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx
	task chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task rst;
		reset_n <= 0;
		repeat (8) @(posedge clock);
		reset_n <= 1;
		foreach (m[i]) m[i] = i < 5 ? 16'h4444 : 16'h0;
	endtask : rst
	task wr_t(input logic [3:0] a, input logic [15:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1;
		@(posedge clock);
		wr <= 0;
		if (a < 5) m[a] = d & 16'h7777;
	endtask : wr_t
	task rd_t(input logic [3:0] a);
		@(posedge clock);
		addr <= a;
		rd <= 1;
		@(posedge clock);
		rd <= 0;
		#1 chk(rdata, a < 5 ? m[a[2:0]] : 16'h0);
	endtask : rd_t
	// Named levels, forwarding and ranks against the model
	task lv;
		for (int p = 0; p < 20; p++) begin
			x[59-3*p -: 3] = m[p/4][4*(3-p%4) +: 3];
			e[p] = src_request[p] && m[p/4][4*(p%4) +: 3] != 3'h0;
			sl[3*p +: 3] = e[p] ? m[p/4][4*(p%4) +: 3] : 3'h0;
		end
		chk({capture_eight_level, capture_seven_level, second_adc_level, external_one_level, timer_four_level,
			compare_four_level, compare_three_level, dma_chan_two_level, uart_two_tx_level, uart_two_rx_level,
			external_two_level, timer_five_level, can_one_event_level, can_one_rx_level, spi_two_event_level,
			spi_two_error_level, capture_five_level, capture_four_level, capture_three_level,
			dma_chan_three_level}, x);
		chk(src_forward, e);
		chk(src_level, sl);
	endtask : lv
	task close_out;
		$display("errors %0d tests %0d", errors, n_tests);
		if (errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : close_out
	initial begin
		#50000 errors++;
		close_out();
	end
	initial begin
		rst();
		for (int a = 0; a < 6; a++) rd_t(a[3:0]);
		for (int k = 0; k < 8; k++) begin
			wr_t(4'h1, {1'b1, 3'(k), 12'h888});
			@(posedge clock);
			#1 lv();
		end
		// Bank five write, then an unmapped offset that must not alias bank nine
		wr_t(4'h0, 16'h7123);
		rd_t(4'h0);
		wr_t(4'hc, 16'h1111);
		rd_t(4'hc);
		lv();
		repeat (24) begin
			seed = nx(seed);
			want <= seed[31:12];
			wr_t({1'b0, seed[18:16]}, seed[15:0]);
			rd_t({1'b0, seed[18:16]});
			lv();
		end
		@(posedge clock);
		rst();
		rd_t(4'h2);
		lv();
		close_out();
	end
endmodule : tb
